// >>> src/pbs_cfg.svh
// Sizes and field positions of the pipelined burst memory.
//
// Overview of operation
// - Selected, not suspended, advance low: load external address; read-write select fixes burst type.
// - Advance high while not suspended increments the burst counter and uses internal address.
// - During advance cycles the read-write select is ignored; load-time type continues.
// - Deselect with advance low stops the burst; bus floats two cycles later; advances stay idle.
// - Selected only when chip select a and c are low and b is high.
// - Suspend gate high at an edge freezes every register and the data pins; reset and output disable still act.
// - Data outputs are high impedance from the first rising edge with reset high.
// - Each active-low byte strobe writes one byte lane and its parity bit.
// - Any combination of byte strobes may write together in one cycle.
// - Burst order select high: beat address is start XOR beat index.
// - Burst order select low: beat address increments modulo four from start.
// - After the fourth beat the counter wraps to its start and keeps counting.
// - Data belongs to the cycle two edges after its address and control were sampled.
// - Output disable high forces the data pins to high impedance asynchronously.
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

`define PBS_ADDR_W  17
`define PBS_LOW_W   2
`define PBS_BASE_W  15
`define PBS_LANES   4
`define PBS_LANE_W  8
`define PBS_DATA_W  32
`define PBS_DEPTH   131072

`endif

// >>> src/pbs_pkg.sv
// Types shared by the pipelined burst memory.
`include "pbs_cfg.svh"

package pbs_pkg;

    // One memory word: four data lanes with one parity bit per lane.
    typedef struct packed {
        logic [`PBS_LANES-1:0]  par;
        logic [`PBS_DATA_W-1:0] dat;
    } pbs_word_t;

    // One pipeline slot: what the memory array must do two edges on.
    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [`PBS_ADDR_W-1:0] addr;
        logic [`PBS_LANES-1:0]  bw_n;
    } pbs_slot_t;

    // Burst in progress, fixed by the last load.
    typedef enum logic [1:0] {
        PBS_IDLE  = 2'b00,
        PBS_READ  = 2'b01,
        PBS_WRITE = 2'b10
    } pbs_burst_t;

endpackage : pbs_pkg

// >>> src/pbs_sram.sv
// Synchronous pipelined burst memory with byte writes and registered outputs.
`timescale 1ns/1ps
`include "pbs_cfg.svh"

module pbs_sram
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    suspend_gate_n_i,
    input  wire logic                    chip_select_a_n_i,
    input  wire logic                    chip_select_b_i,
    input  wire logic                    chip_select_c_n_i,
    input  wire logic                    advance_or_load_i,
    input  wire logic                    read_write_i,
    input  wire logic [3:0]              byte_write_strobe_n_i,
    input  wire logic                    burst_order_select_i,
    input  wire logic                    output_disable_i,
    input  wire logic [16:0]             addr_i,
    input  wire pbs_pkg::pbs_word_t      dq_i,
    output      pbs_pkg::pbs_word_t      dq_o,
    output      logic                    dq_oe_o
);
    import pbs_pkg::*;

    // ==========================================================
    // Decode of the sampled controls
    // ==========================================================

    logic                   ce;
    logic                   sel;
    logic [`PBS_LOW_W-1:0]  next_cnt;
    logic [`PBS_LOW_W-1:0]  next_low;

    pbs_burst_t             burst;
    logic [`PBS_LOW_W-1:0]  start;
    logic [`PBS_LOW_W-1:0]  cnt;
    logic [`PBS_BASE_W-1:0] base;

    pbs_slot_t              slot_a;
    pbs_slot_t              slot_b;
    pbs_word_t              dq_q;
    logic                   oe_q;

    pbs_word_t              mem [0:`PBS_DEPTH-1];

    // A high suspend gate blocks all but reset edges for every register below.
    assign ce  = ~suspend_gate_n_i;
    assign sel = ~chip_select_a_n_i & chip_select_b_i & ~chip_select_c_n_i;

    // Beat index wraps by plain two-bit overflow, so the order repeats.
    assign next_cnt = cnt + 2'h1;

    // Low address bits of the next beat in either burst order.
    always_comb
    begin
        if (burst_order_select_i)
        begin
            next_low = start ^ next_cnt;
        end
        else
        begin
            next_low = start + next_cnt;
        end
    end

    // ==========================================================
    // Burst state and counter
    // ==========================================================

    // Load fixes type and start; deselect ends the burst for good.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            burst <= PBS_IDLE;
            start <= 2'h0;
            cnt   <= 2'h0;
            base  <= 15'h0000;
        end
        else if (ce)
        begin
            if (!advance_or_load_i)
            begin
                if (sel)
                begin
                    burst <= read_write_i ? PBS_READ : PBS_WRITE;
                    start <= addr_i[1:0];
                    cnt   <= 2'h0;
                    base  <= addr_i[16:2];
                end
                else
                begin
                    burst <= PBS_IDLE;
                end
            end
            else if (burst != PBS_IDLE)
            begin
                cnt <= next_cnt;
            end
        end
    end

    // ==========================================================
    // Address and control pipeline
    // ==========================================================

    // First slot: the operation chosen at this edge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slot_a <= '0;
        end
        else if (ce)
        begin
            if (!advance_or_load_i)
            begin
                slot_a.valid <= sel;
                slot_a.write <= ~read_write_i;
                slot_a.addr  <= addr_i;
                slot_a.bw_n  <= byte_write_strobe_n_i;
            end
            else
            begin
                // Read-write select is not looked at here at all.
                slot_a.valid <= (burst != PBS_IDLE);
                slot_a.write <= (burst == PBS_WRITE);
                slot_a.addr  <= {base, next_low};
                slot_a.bw_n  <= byte_write_strobe_n_i;
            end
        end
    end

    // Second slot: delays address and strobes to meet their data.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slot_b <= '0;
        end
        else if (ce)
        begin
            slot_b <= slot_a;
        end
    end

    // ==========================================================
    // Memory array
    // ==========================================================

    // Each lane writes its byte and parity bit; lanes act independently.
    always_ff @(posedge clk_i)
    begin
        if (ce && !rst_i && slot_b.valid && slot_b.write)
        begin
            for (int l = 0; l < `PBS_LANES; l++)
            begin
                if (!slot_b.bw_n[l])
                begin
                    mem[slot_b.addr].dat[l*`PBS_LANE_W +: `PBS_LANE_W] <=
                        dq_i.dat[l*`PBS_LANE_W +: `PBS_LANE_W];
                    mem[slot_b.addr].par[l] <= dq_i.par[l];
                end
            end
        end
    end

    // ==========================================================
    // Output register
    // ==========================================================

    // Reads drive two edges after sampling; writes and idles float.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oe_q <= 1'b0;
            dq_q <= '0;
        end
        else if (ce)
        begin
            oe_q <= slot_b.valid & ~slot_b.write;
            if (slot_b.valid && !slot_b.write)
            begin
                dq_q <= mem[slot_b.addr];
            end
        end
    end

    // The asynchronous disable must act without waiting for an edge.
    assign dq_o    = dq_q;
    assign dq_oe_o = oe_q & ~output_disable_i;

    // ==========================================================
    // Checks
    // ==========================================================

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_load_takes_addr: assert property (
        ce && sel && !advance_or_load_i |=>
            slot_a.valid && slot_a.addr == $past(addr_i)
            && slot_a.write == !$past(read_write_i))
        else $error("load did not capture address or type");

    a_advance_counts: assert property (
        ce && advance_or_load_i && burst != PBS_IDLE |=>
            cnt == $past(next_cnt) && slot_a.valid
            && slot_a.addr[16:2] == base)
        else $error("advance did not step the counter");

    a_advance_keeps_type: assert property (
        ce && advance_or_load_i && burst == PBS_WRITE |=>
            slot_a.write && burst == PBS_WRITE)
        else $error("advance changed the burst type");

    // A load may follow the deselect at once, so the burst state is judged
    // only on the edge right after it; the float is judged two edges on.
    a_deselect_floats: assert property (
        ce && !advance_or_load_i && !sel
            ##1 ce [*2] |=> !oe_q)
        else $error("bus not floating two cycles after deselect");

    a_deselect_stops: assert property (
        ce && !advance_or_load_i && !sel |=> burst == PBS_IDLE)
        else $error("deselect did not end the burst");

    a_idle_cycle_stays_idle: assert property (
        ce && advance_or_load_i && burst == PBS_IDLE |=>
            !slot_a.valid)
        else $error("advance after deselect started an access");

    a_select_decode: assert property (
        ce && !advance_or_load_i && chip_select_b_i == 1'b0 |=>
            !slot_a.valid)
        else $error("access started with chip select b low");

    a_suspend_freezes: assert property (
        !ce |=> $stable(slot_a) && $stable(slot_b) && $stable(oe_q)
            && $stable(dq_q) && $stable(cnt) && $stable(burst))
        else $error("state moved during suspend");

    a_reset_floats: assert property (
        @(posedge clk_i) disable iff (1'b0) rst_i |=> !dq_oe_o)
        else $error("outputs driven after reset");

    a_lane_write: assert property (
        ce && slot_b.valid && slot_b.write && !slot_b.bw_n[0] |=>
            mem[$past(slot_b.addr)].dat[7:0] == $past(dq_i.dat[7:0])
            && mem[$past(slot_b.addr)].par[0] == $past(dq_i.par[0]))
        else $error("lane one write lost");

    a_burst_order: assert property (
        burst_order_select_i && ce && advance_or_load_i
            && burst != PBS_IDLE |=>
            slot_a.addr[1:0] == (start ^ cnt))
        else $error("interleaved beat address wrong");

    a_linear_order: assert property (
        !burst_order_select_i && ce && advance_or_load_i
            && burst != PBS_IDLE |=>
            slot_a.addr[1:0] == 2'(start + cnt))
        else $error("linear beat address wrong");

    a_read_latency: assert property (
        ce && !advance_or_load_i && sel && read_write_i
            ##1 ce ##1 ce |=> oe_q)
        else $error("read data not driven two edges after load");

    a_disable_async: assert property (
        output_disable_i |-> !dq_oe_o)
        else $error("pins driven while output disable is high");

    c_burst_read: cover property (
        ce && !advance_or_load_i && sel && read_write_i
            ##1 (ce && advance_or_load_i) [*3]);

    c_burst_write: cover property (
        ce && !advance_or_load_i && sel && !read_write_i
            ##1 (ce && advance_or_load_i) [*3]);

    c_suspend_mid_burst: cover property (
        burst == PBS_READ && oe_q ##1 !ce ##1 ce);

    c_deselect_after_read: cover property (
        oe_q && ce && !advance_or_load_i && !sel);

endmodule : pbs_sram

// >>> test/pbs_host.sv
// Host controller model driving the burst memory's synchronous inputs.
`timescale 1ns/1ps
module pbs_host
(
    input  wire logic               clk_i,
    output      logic               suspend_gate_n_o,
    output      logic [2:0]         sel_o,
    output      logic               advance_or_load_o,
    output      logic               read_write_o,
    output      logic [3:0]         byte_write_strobe_n_o,
    output      logic               burst_order_select_o,
    output      logic [16:0]        addr_o,
    output      pbs_pkg::pbs_word_t wdata_o
);
    import pbs_pkg::*;
    pbs_word_t wq0;
    pbs_word_t wq1;
    // ==========================================
    // Idle state: deselected, so every edge is a stop cycle.
    initial
    begin
        {suspend_gate_n_o, advance_or_load_o, read_write_o} = 3'b001;
        {sel_o, byte_write_strobe_n_o, burst_order_select_o, addr_o} = {3'b110, 4'hf, 1'b0, 17'h0_0000};
        {wdata_o, wq0, wq1} = '0;
    end
    // One taken edge; write data trails its command by two edges, so it is staged.
    task automatic cyc(input logic v, input logic r, input logic [2:0] s, input logic [3:0] b,
                       input logic [16:0] a, input logic [35:0] wd);
        {suspend_gate_n_o, advance_or_load_o, read_write_o, sel_o} = {1'b0, v, r, s};
        {byte_write_strobe_n_o, addr_o} = {b, a};
        wdata_o = wq1;
        wq1 = wq0;
        wq0 = wd;
        @(posedge clk_i);
        #1;
    endtask : cyc
    // Suspended edge: advance, read-write select, address and write data wiggle to show they are ignored.
    task automatic hold;
        suspend_gate_n_o = 1'b1;
        {advance_or_load_o, read_write_o, addr_o, wdata_o} = ~{advance_or_load_o, read_write_o, addr_o, wdata_o};
        @(posedge clk_i);
        #1;
    endtask : hold
    // Order select changes only between bursts, never inside one.
    task automatic order(input logic o);
        burst_order_select_o = o;
    endtask : order
endmodule : pbs_host

// >>> test/pbs_sram_tb.sv
// Self-checking testbench of the pipelined burst memory.
`timescale 1ns/1ps
module pbs_sram_tb;
    import pbs_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, output_disable_i = 1'b0, sgn, adv, rw, bos, oe, act, wr;
    logic [2:0]  sel;
    logic [3:0]  bw;
    logic [16:0] addr, base;
    logic [1:0]  bt;
    pbs_word_t   wdat, dq;
    logic [35:0] n = '0, m [int];
    logic [36:0] e1 = '0, e2 = '0, snap;
    logic [2:0]  ds [3] = '{3'b110, 3'b000, 3'b011};
    int          miscompares = 0, checks = 0;
    always #25 clk_i = ~clk_i;
    pbs_host pbs_host_inst (.clk_i(clk_i), .suspend_gate_n_o(sgn), .sel_o(sel), .advance_or_load_o(adv),
        .read_write_o(rw), .byte_write_strobe_n_o(bw), .burst_order_select_o(bos), .addr_o(addr), .wdata_o(wdat));
    pbs_sram pbs_sram_inst (.clk_i(clk_i), .rst_i(rst_i), .suspend_gate_n_i(sgn), .chip_select_a_n_i(sel[2]),
        .chip_select_b_i(sel[1]), .chip_select_c_n_i(sel[0]), .advance_or_load_i(adv), .read_write_i(rw),
        .byte_write_strobe_n_i(bw), .burst_order_select_i(bos), .output_disable_i(output_disable_i),
        .addr_i(addr), .dq_i(wdat), .dq_o(dq), .dq_oe_o(oe));
    // ==========================================
    // Compare and count.
    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One operation: the model predicts, and the beat issued two edges ago is judged.
    task automatic op(input logic v, input logic r, input logic [2:0] s, input logic [3:0] b, input logic [16:0] a);
        logic [16:0] ad;
        logic [36:0] ex;
        n = n + 36'h9_e377_9b97;
        if (!v)
            {act, wr, base, bt} = {s == 3'b010, ~r, a, 2'b00};
        else if (act)
            bt = bt + 2'b01;
        ad = {base[16:2], bos ? base[1:0] ^ bt : base[1:0] + bt};
        if (act && wr)
        begin
            m[ad] = m.exists(ad) ? m[ad] : 'x;
            for (int l = 0; l < 4; l++)
                if (!b[l])
                    {m[ad][32+l], m[ad][8*l+:8]} = {n[32+l], n[8*l+:8]};
        end
        ex = (act && !wr) ? {1'b1, m[ad]} : 37'h0;
        pbs_host_inst.cyc(v, r, s, b, a, n);
        chk({oe, e2[36] ? dq : 36'h0}, e2);
        {e2, e1} = {e1, ex};
    endtask : op
    task automatic flush;
        op(1'b0, 1'b1, 3'b110, 4'hf, 17'h0_0000);
        op(1'b0, 1'b1, 3'b110, 4'hf, 17'h0_0000);
    endtask : flush
    // ==========================================
    // Linear write from start 01, six beats so the counter wraps; read select toggles.
    task automatic t_burst_write;
        pbs_host_inst.order(1'b0);
        op(1'b0, 1'b0, 3'b010, 4'h0, 17'h0_0005);
        for (int i = 0; i < 5; i++)
            op(1'b1, i[0], 3'b011, 4'h0, 17'h1_ffff);
        flush();
    endtask : t_burst_write
    // Read the block back in both orders, wrapping past the fourth beat.
    task automatic t_burst_read;
        for (int o = 0; o < 2; o++)
        begin
            pbs_host_inst.order(o[0]);
            op(1'b0, 1'b1, 3'b010, 4'h0, 17'h0_0005);
            for (int i = 0; i < 5; i++)
                op(1'b1, i[0], 3'b000, 4'h0, 17'h0_0000);
            flush();
        end
    endtask : t_burst_read
    // Every strobe pattern, each write read back on the very next edge.
    task automatic t_lanes;
        op(1'b0, 1'b0, 3'b010, 4'h0, 17'h1_2348);
        for (int b = 0; b < 16; b++)
        begin
            op(1'b0, 1'b0, 3'b010, b[3:0], 17'h1_2348);
            op(1'b0, 1'b1, 3'b010, 4'h0, 17'h1_2348);
        end
        flush();
    endtask : t_lanes
    // Each inactive select stops a read burst; later advances stay idle.
    task automatic t_desel;
        foreach (ds[i])
        begin
            op(1'b0, 1'b1, 3'b010, 4'hf, 17'h0_0004);
            op(1'b1, 1'b0, 3'b010, 4'hf, 17'h0_0000);
            op(1'b0, 1'b1, ds[i], 4'hf, 17'h0_0004);
            op(1'b1, 1'b1, 3'b010, 4'hf, 17'h0_0000);
            op(1'b1, 1'b1, 3'b010, 4'hf, 17'h0_0000);
        end
    endtask : t_desel
    // Suspended edges freeze the pins; the disable floats them across an edge.
    task automatic t_suspend;
        op(1'b0, 1'b1, 3'b010, 4'hf, 17'h0_0006);
        op(1'b1, 1'b0, 3'b010, 4'hf, 17'h0_0000);
        op(1'b1, 1'b0, 3'b010, 4'hf, 17'h0_0000);
        snap = {oe, dq};
        pbs_host_inst.hold();
        chk({oe, dq}, snap);
        output_disable_i = 1'b1;
        pbs_host_inst.hold();
        chk({36'h0, oe}, 37'h0);
        output_disable_i = 1'b0;
        pbs_host_inst.hold();
        chk({oe, dq}, snap);
        op(1'b1, 1'b0, 3'b010, 4'hf, 17'h0_0000);
        flush();
    endtask : t_suspend
    task automatic conclude;
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // ==========================================
    // Main sequence; reset holds five cycles.
    initial
    begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        chk({36'h0, oe}, 37'h0);
        t_burst_write();
        t_burst_read();
        t_lanes();
        t_desel();
        t_suspend();
        conclude();
    end
    // The run needs under a hundred cycles; a hang is cut short well beyond that.
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule : pbs_sram_tb
